// ---- verilog/pcsm_defs.svh ----
// Function
// [R01] Enable cleared returns machine to idle.
// [R02] Lead count consumed moves lead-in to engaged.
// [R03] Disengage select 4 returns to lead-in, reloads re-engage count.
// [R04] Disengage select 1, 2, 6 or disable: engaged to idle.
// [R05] Engage select evaluated only while idle.
// [R06] Engage select 0 leaves idle once enabled.
// [R07] Engage select 1 leaves idle on clutch input.
// [R08] Engage select 2 leaves idle at capture event.
// [R09] Master pulses count lead-in down; zero engages.
// [R10] Entry from idle loads initial lead count.
// [R11] Zero lead count engages without master pulse.
// [R12] Count sign sets expected pulse direction.
// [R13] Remaining lead count always readable.
// [R14] Enable defaults to cleared after reset.
// [R15] Disengage select 1: clutch input deasserted.
// [R16] Disengage select 2: fixed signed pulse count elapsed.
// [R17] Counter overflow clears enable, forces idle; code does so for lead count only, disengage count holds.
// [R18] Two-bit state, unused code recovers idle.
// [R19] Clocked updates; reset gives idle, cleared counter.
`ifndef PCSM_DEFS_SVH
`define PCSM_DEFS_SVH

// ====================================================================
// Register offsets
`define PCSM_ADDR_WIDTH 8
`define PCSM_CTRL_OFFSET 8'h00
`define PCSM_STATUS_OFFSET 8'h04
`define PCSM_INIT_LEAD_OFFSET 8'h08
`define PCSM_REENGAGE_LEAD_OFFSET 8'h0C
`define PCSM_DISENGAGE_COUNT_OFFSET 8'h10
`define PCSM_LEAD_REMAIN_OFFSET 8'h14
`define PCSM_DISENGAGE_REMAIN_OFFSET 8'h18

// ====================================================================
// Field positions
`define PCSM_CTRL_ENABLE_BIT 0
`define PCSM_CTRL_ENGAGE_LSB 4
`define PCSM_CTRL_DISENGAGE_LSB 8
`define PCSM_STATUS_OVERFLOW_BIT 4
`define PCSM_STATUS_CLUTCH_BIT 8
`define PCSM_PIN_STEP 0
`define PCSM_PIN_DIR 1
`define PCSM_PIN_CLUTCH 2
`define PCSM_PIN_COUNT 3

// ====================================================================
// Reset values
`define PCSM_ENABLE_RESET 1'b0
`define PCSM_ENGAGE_RESET 2'h0
`define PCSM_DISENGAGE_RESET 3'h0
`define PCSM_COUNT_RESET 32'h00000000

`endif

// ---- verilog/pcsm_pkg.sv ----
package pcsm_pkg;

  typedef enum logic [1:0]
  {
    PCSM_IDLE = 2'b00,
    PCSM_LEAD_IN = 2'b01,
    PCSM_ENGAGED = 2'b10
  } pcsm_clutch_type;

  typedef enum logic [1:0]
  {
    PCSM_ENGAGE_AT_ENABLE = 2'b00,
    PCSM_ENGAGE_AT_CLUTCH = 2'b01,
    PCSM_ENGAGE_AT_CAPTURE = 2'b10
  } pcsm_engage_type;

  typedef enum logic [2:0]
  {
    PCSM_DIS_NEVER = 3'b000,
    PCSM_DIS_CLUTCH_OFF = 3'b001,
    PCSM_DIS_PULSES = 3'b010,
    PCSM_DIS_REENGAGE = 3'b100,
    PCSM_DIS_PULSES_SMOOTH = 3'b110
  } pcsm_disengage_type;

  typedef struct packed
  {
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] stage3;
    logic [2:0] level;
    logic [2:0] rise;
  } pcsm_sync_type;

  typedef struct packed
  {
    pcsm_clutch_type state;
    logic enable;
    logic [1:0] engage_sel;
    logic [2:0] disengage_sel;
    logic [31:0] init_lead;
    logic [31:0] reengage_lead;
    logic [31:0] disengage_count;
    logic [31:0] lead_remain;
    logic [31:0] disengage_remain;
    logic overflow_flag;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pcsm_main_type;

endpackage : pcsm_pkg

// ---- verilog/pcsm_sync_if.sv ----
`timescale 1ns/100ps
interface pcsm_sync_if;
  logic [2:0] level;
  logic [2:0] rise;

  modport source
  (
    output level,
    output rise
  );

  modport sink
  (
    input level,
    input rise
  );
endinterface : pcsm_sync_if

// ---- verilog/pcsm_pin_sync.sv ----
`timescale 1ns/100ps
`include "pcsm_defs.svh"
module pcsm_pin_sync
  import pcsm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] pins,
  pcsm_sync_if.source sync
);

  pcsm_sync_type state_reg;
  pcsm_sync_type state_next;

  // ====================================================================
  // Three stages; a pin change counts once stages two and three agree.
  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = pins;
    state_next.stage2 = state_reg.stage1;
    state_next.stage3 = state_reg.stage2;
    for (int i = 0; i < `PCSM_PIN_COUNT; i++)
    begin
      if (state_reg.stage2[i] == state_reg.stage3[i])
      begin
        state_next.level[i] = state_reg.stage3[i];
      end
    end
    state_next.rise = state_next.level & ~state_reg.level;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sync.level = state_reg.level;
  assign sync.rise = state_reg.rise;

endmodule : pcsm_pin_sync

// ---- verilog/pcsm_clutch.sv ----
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "pcsm_defs.svh"
module pcsm_clutch
  import pcsm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_step_pin,
  input wire logic master_dir_pin,
  input wire logic clutch_input_pin,
  input wire logic capture_event,
  output logic [1:0] clutch_state,
  output logic cam_engaged,
  output logic profile_enable_setting
);

  pcsm_main_type state_reg;
  pcsm_main_type state_next;

  // ====================================================================
  // Pin synchroniser
  pcsm_sync_if sync ();

  pcsm_pin_sync pin_sync
  (
    .clock(clock),
    .reset(reset),
    .pins({clutch_input_pin, master_dir_pin, master_step_pin}),
    .sync(sync)
  );

  // ====================================================================
  // Helpers

  function automatic logic addr_valid(input logic [7:0] addr);
    logic ok;
    ok = 1'b0;
    case (addr)
      `PCSM_CTRL_OFFSET,
      `PCSM_STATUS_OFFSET,
      `PCSM_INIT_LEAD_OFFSET,
      `PCSM_REENGAGE_LEAD_OFFSET,
      `PCSM_DISENGAGE_COUNT_OFFSET,
      `PCSM_LEAD_REMAIN_OFFSET,
      `PCSM_DISENGAGE_REMAIN_OFFSET:
        ok = 1'b1;
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction : addr_valid

  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [3:0] strobe
  );
    logic [31:0] result;
    result = old_value;
    for (int i = 0; i < 4; i++)
    begin
      if (strobe[i])
      begin
        result[i*8 +: 8] = new_value[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge_lanes

  // A forward pulse steps the count down, a reverse pulse steps it up.
  // A count of the wrong sign therefore moves away from zero until it overflows.
  function automatic logic [32:0] step_count(
    input logic [31:0] value,
    input logic reverse
  );
    logic overflow;
    logic [31:0] result;
    overflow = 1'b0;
    if (reverse)
    begin
      overflow = (value == 32'h7FFFFFFF);
      result = value + 32'h00000001;
    end
    else
    begin
      overflow = (value == 32'h80000000);
      result = value - 32'h00000001;
    end
    return {overflow, result};
  endfunction : step_count

  function automatic logic [31:0] ctrl_word(input pcsm_main_type s);
    logic [31:0] word;
    word = 32'h00000000;
    word[`PCSM_CTRL_ENABLE_BIT] = s.enable;
    word[`PCSM_CTRL_ENGAGE_LSB +: 2] = s.engage_sel;
    word[`PCSM_CTRL_DISENGAGE_LSB +: 3] = s.disengage_sel;
    return word;
  endfunction : ctrl_word

  function automatic logic [31:0] read_word(
    input pcsm_main_type s,
    input logic [7:0] addr,
    input logic clutch_level
  );
    logic [31:0] word;
    word = 32'h00000000;
    case (addr)
      `PCSM_CTRL_OFFSET:
        word = ctrl_word(s);
      `PCSM_STATUS_OFFSET:
      begin
        word[1:0] = s.state;
        word[`PCSM_STATUS_OVERFLOW_BIT] = s.overflow_flag;
        word[`PCSM_STATUS_CLUTCH_BIT] = clutch_level;
      end
      `PCSM_INIT_LEAD_OFFSET:
        word = s.init_lead;
      `PCSM_REENGAGE_LEAD_OFFSET:
        word = s.reengage_lead;
      `PCSM_DISENGAGE_COUNT_OFFSET:
        word = s.disengage_count;
      `PCSM_LEAD_REMAIN_OFFSET:
        word = s.lead_remain; // [R13]
      `PCSM_DISENGAGE_REMAIN_OFFSET:
        word = s.disengage_remain;
      default:
        word = 32'h00000000;
    endcase
    return word;
  endfunction : read_word

  // ====================================================================
  // Next state
  always_comb
  begin
    logic pulse;
    logic reverse;
    logic clutch;
    logic write_fire;
    logic engage_ok;
    logic disengage_hit;
    logic [32:0] lead_step;
    logic [32:0] dis_step;
    logic [31:0] ctrl_new;

    pulse = sync.rise[`PCSM_PIN_STEP];
    reverse = sync.level[`PCSM_PIN_DIR];
    clutch = sync.level[`PCSM_PIN_CLUTCH];
    write_fire = 1'b0;
    engage_ok = 1'b0;
    disengage_hit = 1'b0;
    lead_step = step_count(state_reg.lead_remain, reverse);
    dis_step = step_count(state_reg.disengage_remain, reverse);
    ctrl_new = 32'h00000000;
    state_next = state_reg;

    // ==================================================================
    // APB slave: answer in the first access cycle, one wait-free transfer.
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (psel && !penable)
    begin
      state_next.pready = 1'b1;
      state_next.pslverr = !addr_valid(paddr);
      state_next.prdata = pwrite ? 32'h00000000 : read_word(state_reg, paddr, clutch);
    end
    write_fire = psel && penable && state_reg.pready && pwrite && addr_valid(paddr);

    if (write_fire)
    begin
      case (paddr)
        `PCSM_CTRL_OFFSET:
        begin
          ctrl_new = merge_lanes(ctrl_word(state_reg), pwdata, pstrb);
          state_next.enable = ctrl_new[`PCSM_CTRL_ENABLE_BIT];
          state_next.engage_sel = ctrl_new[`PCSM_CTRL_ENGAGE_LSB +: 2];
          state_next.disengage_sel = ctrl_new[`PCSM_CTRL_DISENGAGE_LSB +: 3];
        end
        `PCSM_STATUS_OFFSET:
        begin
          if (pstrb[0] && pwdata[`PCSM_STATUS_OVERFLOW_BIT])
          begin
            state_next.overflow_flag = 1'b0;
          end
        end
        `PCSM_INIT_LEAD_OFFSET:
          state_next.init_lead = merge_lanes(state_reg.init_lead, pwdata, pstrb);
        `PCSM_REENGAGE_LEAD_OFFSET:
          state_next.reengage_lead = merge_lanes(state_reg.reengage_lead, pwdata, pstrb);
        `PCSM_DISENGAGE_COUNT_OFFSET:
          state_next.disengage_count = merge_lanes(state_reg.disengage_count, pwdata, pstrb);
        default:
        begin
          state_next.prdata = state_reg.prdata;
        end
      endcase
    end

    // ==================================================================
    // Engage condition, looked at only from idle.
    case (state_reg.engage_sel)
      PCSM_ENGAGE_AT_ENABLE:
        engage_ok = 1'b1; // [R06]
      PCSM_ENGAGE_AT_CLUTCH:
        engage_ok = clutch; // [R07]
      PCSM_ENGAGE_AT_CAPTURE:
        engage_ok = capture_event; // [R08]
      default:
        engage_ok = 1'b0;
    endcase

    // ==================================================================
    // Clutch state machine
    case (state_reg.state)
      PCSM_IDLE:
      begin
        if (state_reg.enable && engage_ok) // [R05]
        begin
          state_next.state = PCSM_LEAD_IN;
          state_next.lead_remain = state_reg.init_lead; // [R10]
        end
      end
      PCSM_LEAD_IN:
      begin
        if (!state_reg.enable)
        begin
          state_next.state = PCSM_IDLE; // [R01]
        end
        else if (state_reg.lead_remain == 32'h00000000) // [R11]
        begin
          state_next.state = PCSM_ENGAGED; // [R02]
          state_next.disengage_remain = state_reg.disengage_count;
        end
        else if (pulse)
        begin
          // A wrong-signed count only grows, so it can never engage. [R12]
          if (lead_step[32])
          begin
            state_next.enable = 1'b0; // [R17]
            state_next.overflow_flag = 1'b1;
            state_next.state = PCSM_IDLE; // [R17]
          end
          else
          begin
            state_next.lead_remain = lead_step[31:0]; // [R09]
          end
        end
      end
      PCSM_ENGAGED:
      begin
        case (state_reg.disengage_sel)
          PCSM_DIS_CLUTCH_OFF:
            disengage_hit = !clutch; // [R15]
          PCSM_DIS_PULSES,
          PCSM_DIS_PULSES_SMOOTH,
          PCSM_DIS_REENGAGE:
          begin
            disengage_hit = (state_reg.disengage_remain == 32'h00000000); // [R16]
            if (!disengage_hit && pulse && !dis_step[32])
            begin
              state_next.disengage_remain = dis_step[31:0];
            end
          end
          default:
            disengage_hit = 1'b0;
        endcase
        if (!state_reg.enable)
        begin
          state_next.state = PCSM_IDLE; // [R04]
        end
        else if (disengage_hit && state_reg.disengage_sel == PCSM_DIS_REENGAGE)
        begin
          state_next.state = PCSM_LEAD_IN; // [R03]
          state_next.lead_remain = state_reg.reengage_lead; // [R03]
        end
        else if (disengage_hit)
        begin
          state_next.state = PCSM_IDLE; // [R04]
        end
      end
      default:
      begin
        state_next.state = PCSM_IDLE; // [R18]
        state_next.lead_remain = 32'h00000000;
      end
    endcase

    // The overflow flag is set by hardware; a set in the clearing cycle wins.
    if (state_reg.state == PCSM_LEAD_IN && state_reg.enable && pulse
        && state_reg.lead_remain != 32'h00000000 && lead_step[32])
    begin
      state_next.overflow_flag = 1'b1;
      state_next.enable = 1'b0;
    end
  end

  // ====================================================================
  // State register
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '0; // [R19]
      state_reg.state <= PCSM_IDLE; // [R19]
      state_reg.enable <= `PCSM_ENABLE_RESET; // [R14]
      state_reg.engage_sel <= `PCSM_ENGAGE_RESET;
      state_reg.disengage_sel <= `PCSM_DISENGAGE_RESET;
      state_reg.lead_remain <= `PCSM_COUNT_RESET; // [R19]
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ====================================================================
  // Outputs
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign clutch_state = state_reg.state;
  assign cam_engaged = (state_reg.state == PCSM_ENGAGED);
  assign profile_enable_setting = state_reg.enable;

endmodule : pcsm_clutch

// ---- verification/pcsm_clutch_assertions.sv ----
`timescale 1ns/100ps
`include "pcsm_defs.svh"
module pcsm_clutch_assertions
  import pcsm_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_step_pin,
  input wire logic master_dir_pin,
  input wire logic clutch_input_pin,
  input wire logic capture_event,
  input wire logic [1:0] clutch_state,
  input wire logic cam_engaged,
  input wire logic profile_enable_setting
);
  // ==========
  // Shadow of the select fields; full-word writes are assumed.
  logic [1:0] eng_reg;
  logic [2:0] dis_reg;
  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      eng_reg <= 2'h0;
      dis_reg <= 3'h0;
    end
    else if (psel && penable && pready && pwrite && paddr == `PCSM_CTRL_OFFSET)
    begin
      eng_reg <= pwdata[5:4];
      dis_reg <= pwdata[10:8];
    end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========
  // Properties
  property p_state_code;
    clutch_state != 2'h3;
  endproperty
  a_state_code: assert property (p_state_code) else $error("unused state");
  property p_disable_idle;
    !profile_enable_setting [*2] |-> clutch_state == 2'h0;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("not idle");
  property p_engage_path;
    $rose(cam_engaged) |-> $past(clutch_state) == 2'h1;
  endproperty
  a_engage_path: assert property (p_engage_path) else $error("bad engage");
  property p_enable_leave;
    $rose(profile_enable_setting) && eng_reg == 2'h0 |=> clutch_state != 2'h0;
  endproperty
  a_enable_leave: assert property (p_enable_leave) else $error("no start");
  property p_clutch_leave;
    clutch_state == 2'h0 && profile_enable_setting && eng_reg == 2'h1 && $rose(clutch_input_pin)
      |-> ##[1:6] clutch_state != 2'h0;
  endproperty
  a_clutch_leave: assert property (p_clutch_leave) else $error("no clutch start");
  property p_capture;
    clutch_state == 2'h0 && eng_reg == 2'h2
      |=> (clutch_state == 2'h1) == $past(capture_event && profile_enable_setting);
  endproperty
  a_capture: assert property (p_capture) else $error("capture start");
  property p_reengage;
    clutch_state == 2'h2 ##1 clutch_state == 2'h1 |-> dis_reg == 3'h4;
  endproperty
  a_reengage: assert property (p_reengage) else $error("bad re-entry");
  property p_clutch_off;
    clutch_state == 2'h2 && dis_reg == 3'h1 && $fell(clutch_input_pin)
      |-> ##[1:6] clutch_state == 2'h0;
  endproperty
  a_clutch_off: assert property (p_clutch_off) else $error("no release");
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer");
  c_engaged: cover property ($rose(cam_engaged));
  c_reengage: cover property (clutch_state == 2'h2 ##1 clutch_state == 2'h1);
  c_capture: cover property (capture_event && clutch_state == 2'h0 && profile_enable_setting);
endmodule : pcsm_clutch_assertions
bind pcsm_clutch pcsm_clutch_assertions u_pcsm_clutch_assertions
(
  .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .master_step_pin, .master_dir_pin, .clutch_input_pin, .capture_event,
  .clutch_state, .cam_engaged, .profile_enable_setting
);

// ---- verification/pcsm_master_model.sv ----
`timescale 1ns/100ps
module pcsm_master_model
(
  input wire logic clock,
  output logic step,
  output logic dir,
  output logic clutch
);
  // ==========
  // Step rests low between bursts, so no stray edge is ever counted.
  initial
  begin
    step = 1'b0;
    dir = 1'b0;
    clutch = 1'b0;
  end
  // Four cycles per phase, because the pins pass three flops.
  task automatic pulses(input int n, input logic rev);
    dir <= rev;
    repeat (n)
    begin
      repeat (4) @(posedge clock);
      step <= 1'b1;
      repeat (4) @(posedge clock);
      step <= 1'b0;
    end
    repeat (6) @(posedge clock);
  endtask : pulses
  task automatic set_clutch(input logic v);
    clutch <= v;
    repeat (8) @(posedge clock);
  endtask : set_clutch
endmodule : pcsm_master_model

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`include "pcsm_defs.svh"
module testbench
  import pcsm_pkg::*;
;
  // ==========
  localparam logic [7:0] ctrl_a = `PCSM_CTRL_OFFSET;
  localparam logic [7:0] stat_a = `PCSM_STATUS_OFFSET;
  localparam logic [7:0] init_a = `PCSM_INIT_LEAD_OFFSET;
  localparam logic [7:0] reen_a = `PCSM_REENGAGE_LEAD_OFFSET;
  localparam logic [7:0] disc_a = `PCSM_DISENGAGE_COUNT_OFFSET;
  localparam logic [7:0] lrem_a = `PCSM_LEAD_REMAIN_OFFSET;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, capture_event;
  logic step, dir, clutch, cam_engaged, profile_enable_setting, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] clutch_state;
  int fails, cmp_count;
  pcsm_clutch u_pcsm_clutch
  (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_step_pin(step), .master_dir_pin(dir),
    .clutch_input_pin(clutch), .capture_event(capture_event), .clutch_state(clutch_state),
    .cam_engaged(cam_engaged), .profile_enable_setting(profile_enable_setting)
  );
  pcsm_master_model u_pcsm_master_model
  (
    .clock(clock),
    .step(step),
    .dir(dir),
    .clutch(clutch)
  );
  always #5 clock = ~clock;
  task automatic close_out;
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave.
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, q);
  endtask : rdc
  task automatic st(input logic [1:0] e);
    int n;
    for (n = 0; n < 30 && clutch_state !== e; n++)
      @(posedge clock);
    chk("state", {30'h0, e}, {30'h0, clutch_state});
  endtask : st
  // ==========
  // Scenarios
  task automatic t_reset;
    rdc(ctrl_a, 32'h0);
    rdc(lrem_a, 32'h0);
    st(2'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk("error", 32'h1, {31'h0, err});
    apb(1'b1, lrem_a, 32'h5);
    rdc(lrem_a, 32'h0);
  endtask : t_reset
  task automatic t_sel0;
    apb(1'b1, init_a, 32'h3);
    apb(1'b1, ctrl_a, 32'h1);
    st(2'h1);
    rdc(lrem_a, 32'h3);
    u_pcsm_master_model.pulses(2, 1'b0);
    rdc(lrem_a, 32'h1);
    u_pcsm_master_model.pulses(1, 1'b0);
    st(2'h2);
    chk("engaged", 32'h1, {31'h0, cam_engaged});
    apb(1'b1, ctrl_a, 32'h0);
    st(2'h0);
    chk("engaged", 32'h0, {31'h0, cam_engaged});
    apb(1'b1, init_a, 32'h0);
    apb(1'b1, ctrl_a, 32'h1);
    st(2'h2);
    apb(1'b1, ctrl_a, 32'h0);
  endtask : t_sel0
  task automatic t_clutch;
    apb(1'b1, ctrl_a, 32'h111);
    repeat (10) @(posedge clock);
    st(2'h0);
    u_pcsm_master_model.set_clutch(1'b1);
    st(2'h2);
    u_pcsm_master_model.set_clutch(1'b0);
    st(2'h0);
    apb(1'b1, init_a, 32'h1);
    apb(1'b1, ctrl_a, 32'h21);
    u_pcsm_master_model.set_clutch(1'b1);
    st(2'h0);
    u_pcsm_master_model.set_clutch(1'b0);
    capture_event <= 1'b1;
    @(posedge clock);
    capture_event <= 1'b0;
    st(2'h1);
    apb(1'b1, ctrl_a, 32'h0);
  endtask : t_clutch
  task automatic t_disengage;
    logic [2:0] dsel [3] = '{3'h2, 3'h4, 3'h6};
    logic [1:0] dst [3] = '{2'h0, 2'h1, 2'h0};
    apb(1'b1, init_a, 32'h0);
    apb(1'b1, reen_a, 32'h5);
    apb(1'b1, disc_a, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      // Engage on capture, so that an idle machine stays idle afterwards.
      apb(1'b1, ctrl_a, {21'h0, dsel[i], 8'h21});
      capture_event <= 1'b1;
      @(posedge clock);
      capture_event <= 1'b0;
      st(2'h2);
      u_pcsm_master_model.pulses(1, 1'b0);
      st(dst[i]);
      if (i == 1)
        rdc(lrem_a, 32'h5);
      apb(1'b1, ctrl_a, 32'h0);
      st(2'h0);
    end
  endtask : t_disengage
  task automatic t_wrong_dir;
    apb(1'b1, init_a, 32'h2);
    apb(1'b1, ctrl_a, 32'h1);
    u_pcsm_master_model.pulses(1, 1'b1);
    rdc(lrem_a, 32'h3);
    st(2'h1);
    apb(1'b1, ctrl_a, 32'h0);
    apb(1'b1, init_a, 32'h7FFFFFFF);
    apb(1'b1, ctrl_a, 32'h1);
    u_pcsm_master_model.pulses(1, 1'b1);
    st(2'h0);
    chk("enable", 32'h0, {31'h0, profile_enable_setting});
    rdc(stat_a, 32'h10);
    apb(1'b1, stat_a, 32'h10);
    rdc(stat_a, 32'h0);
  endtask : t_wrong_dir
  initial
  begin
    #100000;
    fails++;
    close_out();
  end
  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    capture_event = 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_reset();
    t_sel0();
    t_clutch();
    t_disengage();
    t_wrong_dir();
    close_out();
  end
endmodule : testbench
